// ===== logic/mxdec_pkg.sv
// Constants, codes and types shared by the bus matrix address decoder
package mxdec_pkg;

    // Matrix shape
    localparam int MXDEC_MASTERS = 9;                  // Number of bus masters
    localparam int MXDEC_N_CS    = 9;                  // External chip selects in total
    localparam int MXDEC_N_BLK   = 5;                  // 16 KB blocks of the 80 KB SRAM

    // Address field positions
    localparam int BANK_MSB  = 31;                     // Bank number, top of address
    localparam int BANK_LSB  = 28;
    localparam int REG_MSB   = 27;                     // 1 MB region inside bank zero
    localparam int REG_LSB   = 20;
    localparam int OFF_MSB   = 19;                     // Offset inside a 1 MB region
    localparam int BLK_SHIFT = 14;                     // 16 KB block granule
    localparam int IDX_W     = OFF_MSB - BLK_SHIFT + 1;

    // Bank numbers
    localparam logic [3:0] BANK_INT    = 4'h0;         // Internal memories
    localparam logic [3:0] BANK_CS_LO  = 4'h1;         // First chip select bank
    localparam logic [3:0] BANK_CS_HI  = 4'h9;         // Last chip select bank
    localparam logic [3:0] BANK_EBI0_HI = 4'h6;        // Last bank on first interface
    localparam logic [3:0] BANK_PERIPH = 4'hf;         // Peripheral bridge

    // Regions inside bank zero, 1 MB each
    localparam logic [7:0] REG_BOOT   = 8'h00;         // Boot memory alias
    localparam logic [7:0] REG_SRAM_A = 8'h01;         // Instruction coupled area
    localparam logic [7:0] REG_SRAM_B = 8'h02;         // Data coupled area
    localparam logic [7:0] REG_SRAM_C = 8'h03;         // Shared area
    localparam logic [7:0] REG_ROM    = 8'h04;         // ROM home window
    localparam logic [7:0] REG_SRAM16 = 8'h05;         // 16 KB SRAM
    localparam logic [7:0] REG_LCD    = 8'h07;         // Display register window
    localparam logic [7:0] REG_DMAC   = 8'h08;         // DMA register window
    localparam logic [7:0] REG_USBH   = 8'h09;         // USB host register window

    // Window sizes in bytes
    localparam logic [19:0] ROM_BYTES    = 20'h20000;  // 128 KB
    localparam logic [19:0] SRAM16_BYTES = 20'h04000;  // 16 KB
    localparam logic [19:0] UI_BYTES     = 20'h04000;  // Register window span

    // SRAM partition
    localparam int          SZ_W     = 2;              // Area size in 16 KB units
    localparam logic [1:0]  SZ_ZERO  = 2'h0;
    localparam logic [1:0]  SZ_ONE   = 2'h1;
    localparam logic [1:0]  SZ_MAX   = 2'h2;           // 32 KB ceiling
    localparam logic [2:0]  BLK_TOTAL = 3'h5;          // 80 KB in units
    localparam logic [2:0]  BLK_C_FIX = 3'h4;          // Block always in area C
    localparam logic [2:0]  BLK_A0    = 3'h1;          // First block of area A
    localparam logic [2:0]  BLK_A1    = 3'h0;          // Second block of area A
    localparam logic [2:0]  BLK_B0    = 3'h3;          // First block of area B
    localparam logic [2:0]  BLK_B1    = 3'h2;          // Second block of area B

    // Master numbers with special rights
    localparam logic [3:0] M_DMAC  = 4'h3;
    localparam logic [3:0] M_PDC   = 4'h6;
    localparam logic [3:0] M_CPU_D = 4'h7;
    localparam logic [3:0] M_CPU_I = 4'h8;

    // Boot pin settle time after reset release, in cycles
    localparam logic [2:0] BOOT_SETTLE_CYC = 3'h4;

    // Slave selected by a decoded access, one-hot
    typedef enum logic [9:0] {
        SL_NONE   = 10'h001,
        SL_ROM    = 10'h002,
        SL_SRAM80 = 10'h004,
        SL_SRAM16 = 10'h008,
        SL_LCD_UI = 10'h010,
        SL_DMA_UI = 10'h020,
        SL_USBH_UI = 10'h040,
        SL_EBI0   = 10'h080,
        SL_EBI1   = 10'h100,
        SL_BRIDGE = 10'h200
    } mxdec_slave_t;

    // Boot pin capture state, one-hot
    typedef enum logic [1:0] {
        BOOT_SETTLE = 2'h1,
        BOOT_HELD   = 2'h2
    } mxdec_boot_t;

    // Result of one decode
    typedef struct packed {
        mxdec_slave_t             slave;
        logic [MXDEC_N_CS-1:0]    cs;
        logic [2:0]               blk;
    } mxdec_route_t;

endpackage

// ===== logic/mxdec_sync3.sv
// Three-stage synchroniser for a pin level with agreement filter
`timescale 1ns/1ps
module mxdec_sync3 (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Pin side
    input  wire logic pin_in,
    // Clock domain side
    output logic      level_out
);

    logic ff1_r;  // Metastable catch, read only by ff2_r
    logic ff2_r;  // Second stage
    logic ff3_r;  // Third stage

    // Shift chain; first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ff1_r <= 1'h0;
            ff2_r <= 1'h0;
            ff3_r <= 1'h0;
        end else begin
            ff1_r <= pin_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // Accept a new level only once two stages agree, rejecting a single glitch
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            level_out <= 1'h0;
        end else if (ff2_r == ff3_r) begin
            level_out <= ff3_r;
        end
    end

endmodule

// ===== logic/mxdec_top.sv
// Bus matrix address decode, access permission and boot map for nine masters
// Behaviour
// - Sixteen 256 MB banks from top bits
// - Banks one to nine drive chip selects
// - Bank zero internal, 1 MB second decode
// - Bank fifteen goes to peripheral bridge
// - Unassigned area access returns abort
// - Every master has its own decoder
// - Memories and external buses open to all
// - Register windows and bridge restricted by master
// - Address zero: ROM, chip select, or area C
// - Area C at zero only for processor
// - Areas A and B at fixed windows
// - Area C always at its window
// - A, B sized 16 KB steps; C remainder
// - Memory access completes in one cycle
// - Forbidden paths are unreachable
// - Reset gives all 80 KB to C
// - Boot pin sampled once after reset release
`timescale 1ns/1ps
module mxdec_top
    import mxdec_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Boot strap pin
    input  wire logic                  boot_source_pin,
    // Configuration write
    input  wire logic                  cfg_wr,
    input  wire logic                  cfg_alias,
    input  wire logic [SZ_W-1:0]       cfg_a_size,
    input  wire logic [SZ_W-1:0]       cfg_b_size,
    // Configuration and boot status
    output logic                       boot_done,
    output logic                       boot_rom,
    output logic                       alias_on,
    output logic [SZ_W-1:0]            a_size,
    output logic [SZ_W-1:0]            b_size,
    output logic [2:0]                 c_size,
    // Master requests
    input  wire logic [MXDEC_MASTERS-1:0] m_req,
    input  wire logic [31:0]           m_addr [MXDEC_MASTERS],
    // Master answers, one cycle after the request
    output logic [MXDEC_MASTERS-1:0]   m_ack,
    output logic [MXDEC_MASTERS-1:0]   m_err,
    output mxdec_slave_t               m_slave [MXDEC_MASTERS],
    output logic [MXDEC_N_CS-1:0]      m_cs [MXDEC_MASTERS],
    output logic [2:0]                 m_blk [MXDEC_MASTERS],
    output logic [BLK_SHIFT-1:0]       m_blk_off [MXDEC_MASTERS]
);

    // True for the two processor ports
    function automatic logic is_cpu(input logic [3:0] mid);
        is_cpu = (mid == M_CPU_D) || (mid == M_CPU_I);
    endfunction

    // Masters allowed through the peripheral bridge
    function automatic logic bridge_ok(input logic [3:0] mid);
        bridge_ok = is_cpu(mid) || (mid == M_DMAC) || (mid == M_PDC);
    endfunction

    // Clamp a requested area size to the 32 KB ceiling
    function automatic logic [SZ_W-1:0] clamp_sz(input logic [SZ_W-1:0] s);
        clamp_sz = (s > SZ_MAX) ? SZ_MAX : s;
    endfunction

    // Physical block behind the k-th 16 KB slot of area C.
    // Slot zero is the fixed block; later slots take free blocks from the top down,
    // so repartitioning moves data under software's feet, a known hazard.
    function automatic logic [2:0] c_block(input logic [IDX_W-1:0] idx,
                                           input logic [SZ_W-1:0]  a,
                                           input logic [SZ_W-1:0]  b);
        logic [MXDEC_N_BLK-1:0] used;
        logic [IDX_W-1:0]       n;
        c_block = BLK_C_FIX;
        used = '0;
        used[BLK_C_FIX] = 1'h1;
        used[BLK_A0] = (a >= SZ_ONE);
        used[BLK_A1] = (a >= SZ_MAX);
        used[BLK_B0] = (b >= SZ_ONE);
        used[BLK_B1] = (b >= SZ_MAX);
        n = IDX_W'(1);
        for (int k = MXDEC_N_BLK - 1; k >= 0; k--) begin
            if (!used[k]) begin
                if (n == idx) begin
                    c_block = 3'(k);
                end
                n = n + IDX_W'(1);
            end
        end
    endfunction

    // Area C slot lookup, shared by the home window and the zero alias
    function automatic mxdec_route_t area_c(input logic [19:0]   off,
                                            input logic [2:0]    csz,
                                            input logic [SZ_W-1:0] a,
                                            input logic [SZ_W-1:0] b);
        logic [IDX_W-1:0] idx;
        idx = off[OFF_MSB:BLK_SHIFT];
        area_c = '{slave: SL_NONE, cs: '0, blk: '0};
        if (idx < IDX_W'(csz)) begin
            area_c.slave = SL_SRAM80;
            area_c.blk   = c_block(idx, a, b);
        end
    endfunction

    // Full decode of one address for one master
    function automatic mxdec_route_t decode(input logic [31:0]     addr,
                                            input logic [3:0]      mid,
                                            input logic            alias_b,
                                            input logic            rom_b,
                                            input logic [SZ_W-1:0] a,
                                            input logic [SZ_W-1:0] b,
                                            input logic [2:0]      csz);
        logic [3:0]       bank;
        logic [7:0]       rgn;
        logic [19:0]      off;
        logic [IDX_W-1:0] idx;
        bank = addr[BANK_MSB:BANK_LSB];
        rgn  = addr[REG_MSB:REG_LSB];
        off  = addr[OFF_MSB:0];
        idx  = off[OFF_MSB:BLK_SHIFT];
        decode = '{slave: SL_NONE, cs: '0, blk: '0};
        if (bank == BANK_INT) begin
            case (rgn)
                REG_BOOT: begin
                    if (alias_b && is_cpu(mid)) begin
                        decode = area_c(off, csz, a, b);
                    end else if (rom_b) begin
                        if (off < ROM_BYTES) begin
                            decode.slave = SL_ROM;
                        end
                    end else begin
                        decode.slave = SL_EBI0;
                        decode.cs[0] = 1'h1;
                    end
                end
                REG_SRAM_A: begin
                    if (idx < IDX_W'(a)) begin
                        decode.slave = SL_SRAM80;
                        decode.blk   = (idx == '0) ? BLK_A0 : BLK_A1;
                    end
                end
                REG_SRAM_B: begin
                    if (idx < IDX_W'(b)) begin
                        decode.slave = SL_SRAM80;
                        decode.blk   = (idx == '0) ? BLK_B0 : BLK_B1;
                    end
                end
                REG_SRAM_C: begin
                    decode = area_c(off, csz, a, b);
                end
                REG_ROM: begin
                    if (off < ROM_BYTES) begin
                        decode.slave = SL_ROM;
                    end
                end
                REG_SRAM16: begin
                    if (off < SRAM16_BYTES) begin
                        decode.slave = SL_SRAM16;
                    end
                end
                REG_LCD: begin
                    if (off < UI_BYTES && is_cpu(mid)) begin
                        decode.slave = SL_LCD_UI;
                    end
                end
                REG_DMAC: begin
                    if (off < UI_BYTES && is_cpu(mid)) begin
                        decode.slave = SL_DMA_UI;
                    end
                end
                REG_USBH: begin
                    if (off < UI_BYTES && is_cpu(mid)) begin
                        decode.slave = SL_USBH_UI;
                    end
                end
                default: begin
                    decode.slave = SL_NONE;
                end
            endcase
        end else if (bank >= BANK_CS_LO && bank <= BANK_CS_HI) begin
            // One chip select per bank, split over the two interfaces
            decode.cs[4'(bank - BANK_CS_LO)] = 1'h1;
            decode.slave = (bank <= BANK_EBI0_HI) ? SL_EBI0 : SL_EBI1;
        end else if (bank == BANK_PERIPH) begin
            if (bridge_ok(mid)) begin
                decode.slave = SL_BRIDGE;
            end
        end
    endfunction

    // Boot capture state
    mxdec_boot_t boot_st_r;          // Capture state
    logic [2:0]  settle_cnt_r;       // Cycles since reset release
    logic        pin_sync;           // Filtered boot pin level

    // Pin passes three stages before the decoder looks at it
    mxdec_sync3 u_boot_sync (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pin_in    (boot_source_pin),
        .level_out (pin_sync)
    );

    // Capture the boot pin once after reset; held until the next reset.
    // Reset value selects ROM so address zero is defined while settling.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            boot_st_r    <= BOOT_SETTLE;
            settle_cnt_r <= '0;
            boot_rom     <= 1'h1;
            boot_done    <= 1'h0;
        end else begin
            case (boot_st_r)
                BOOT_SETTLE: begin
                    if (settle_cnt_r == BOOT_SETTLE_CYC) begin
                        boot_rom  <= pin_sync;
                        boot_done <= 1'h1;
                        boot_st_r <= BOOT_HELD;
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 3'h1;
                    end
                end
                BOOT_HELD: begin
                    boot_st_r <= BOOT_HELD;
                end
                default: begin
                    boot_st_r <= BOOT_SETTLE;
                end
            endcase
        end
    end

    // Configuration is latched on the write strobe, so every access decoded
    // from the next edge on sees the whole new setting at once, never half.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alias_on <= 1'h0;
            a_size   <= SZ_ZERO;
            b_size   <= SZ_ZERO;
            c_size   <= BLK_TOTAL;
        end else if (cfg_wr) begin
            // Alias is trusted to be set only once booted
            alias_on <= cfg_alias;
            a_size   <= clamp_sz(cfg_a_size);
            b_size   <= clamp_sz(cfg_b_size);
            c_size   <= BLK_TOTAL - 3'(clamp_sz(cfg_a_size))
                        - 3'(clamp_sz(cfg_b_size));
        end
    end

    // One decoder and answer register per master
    genvar gm;
    generate
        for (gm = 0; gm < MXDEC_MASTERS; gm++) begin : g_master
            mxdec_route_t rt;   // This master's decode of its current address

            // Own decoder; only the address and master number differ between copies
            assign rt = decode(m_addr[gm], 4'(gm), alias_on, boot_rom,
                               a_size, b_size, c_size);

            // Answer registered one cycle after the request, every slave alike
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    m_ack[gm]     <= 1'h0;
                    m_err[gm]     <= 1'h0;
                    m_slave[gm]   <= SL_NONE;
                    m_cs[gm]      <= '0;
                    m_blk[gm]     <= '0;
                    m_blk_off[gm] <= '0;
                end else if (m_req[gm]) begin
                    m_ack[gm]     <= 1'h1;
                    m_err[gm]     <= (rt.slave == SL_NONE);
                    m_slave[gm]   <= rt.slave;
                    m_cs[gm]      <= rt.cs;
                    m_blk[gm]     <= rt.blk;
                    m_blk_off[gm] <= m_addr[gm][BLK_SHIFT-1:0];
                end else begin
                    // Idle: selects drop so no slave sees a stale access
                    m_ack[gm]     <= 1'h0;
                    m_err[gm]     <= 1'h0;
                    m_slave[gm]   <= SL_NONE;
                    m_cs[gm]      <= '0;
                    m_blk[gm]     <= '0;
                    m_blk_off[gm] <= '0;
                end
            end
        end
    endgenerate

endmodule

// ===== sim/mxdec_properties.sv
// Checker for matrix decoder answers, rights and configuration
`timescale 1ns/1ps
module mxdec_properties
    import mxdec_pkg::*;
(
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rstn,
    // Boot and configuration
    input wire logic                     boot_source_pin,
    input wire logic                     cfg_wr,
    input wire logic                     cfg_alias,
    input wire logic [SZ_W-1:0]          cfg_a_size,
    input wire logic [SZ_W-1:0]          cfg_b_size,
    input wire logic                     boot_done,
    input wire logic                     boot_rom,
    input wire logic                     alias_on,
    input wire logic [SZ_W-1:0]          a_size,
    input wire logic [SZ_W-1:0]          b_size,
    input wire logic [2:0]               c_size,
    // Master side
    input wire logic [MXDEC_MASTERS-1:0] m_req,
    input wire logic [31:0]              m_addr [MXDEC_MASTERS],
    input wire logic [MXDEC_MASTERS-1:0] m_ack,
    input wire logic [MXDEC_MASTERS-1:0] m_err,
    input mxdec_slave_t                  m_slave [MXDEC_MASTERS],
    input wire logic [MXDEC_N_CS-1:0]    m_cs [MXDEC_MASTERS],
    input wire logic [2:0]               m_blk [MXDEC_MASTERS],
    input wire logic [BLK_SHIFT-1:0]     m_blk_off [MXDEC_MASTERS]
);
    // Single clock domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // One set per master
    for (genvar i = 0; i < MXDEC_MASTERS; i++) begin : g_m
        // Bridge masters: DMA, peripheral DMA, processor
        localparam bit MAY_BR = (i == 3) || (i == 6) || (i >= 7);
        sequence s_bridge;
            m_req[i] && m_addr[i][31:28] == BANK_PERIPH;
        endsequence
        sequence s_ext;
            m_req[i] && m_addr[i][31:28] inside {[4'h1:4'h9]};
        endsequence
        a_ack_follows: assert property (m_req[i] |=> m_ack[i] &&
            m_blk_off[i] == $past(m_addr[i][BLK_SHIFT-1:0]))
            else $error("answer missing one cycle after request");
        a_no_stray_ack: assert property (!m_req[i] |=> !m_ack[i])
            else $error("answer without request");
        a_abort_no_slave: assert property (m_err[i] |->
            m_ack[i] && m_slave[i] == SL_NONE && m_cs[i] == '0)
            else $error("abort carries a slave or chip select");
        a_bank_cs_map: assert property (s_ext |=> !m_err[i] &&
            m_cs[i] == 9'h001 << ($past(m_addr[i][31:28]) - 4'h1))
            else $error("external bank drives wrong chip select");
        a_unused_abort: assert property (m_req[i] &&
            m_addr[i][31:28] inside {[4'ha:4'he]} |=> m_err[i])
            else $error("unused bank not aborted");
        a_bridge_rights: assert property (s_bridge |=> m_err[i] == !MAY_BR)
            else $error("bridge access right wrong");
        a_sram_c_home: assert property (m_req[i] && m_addr[i] == 32'h0030_0000 |=>
            m_slave[i] == SL_SRAM80 && m_blk[i] == 3'h4)
            else $error("area C base not at its block");
    end

    a_c_remainder: assert property (c_size == BLK_TOTAL - 3'(a_size) - 3'(b_size))
        else $error("area C size is not the remainder");
    a_size_clamp: assert property (cfg_wr |=>
        a_size == ($past(cfg_a_size) > SZ_MAX ? SZ_MAX : $past(cfg_a_size)))
        else $error("area A size not clamped");
    a_boot_held: assert property (boot_done |=> boot_done && $stable(boot_rom))
        else $error("captured boot level changed");
    a_alias_write: assert property (cfg_wr |=> alias_on == $past(cfg_alias))
        else $error("alias bit not taken with write");
endmodule

bind mxdec_top mxdec_properties u_props (.ref_clk, .rstn, .boot_source_pin, .cfg_wr, .cfg_alias,
    .cfg_a_size, .cfg_b_size, .boot_done, .boot_rom, .alias_on, .a_size, .b_size, .c_size,
    .m_req, .m_addr, .m_ack, .m_err, .m_slave, .m_cs, .m_blk, .m_blk_off);

// ===== sim/mxdec_master_model.sv
// Bus master model: one request, answer read a cycle later
`timescale 1ns/1ps
module mxdec_master_model
    import mxdec_pkg::*;
(
    // Clock
    input wire logic                     ref_clk,
    // Requests towards the decoder
    output logic [MXDEC_MASTERS-1:0]     m_req,
    output logic [31:0]                  m_addr [MXDEC_MASTERS],
    // Answers from the decoder
    input wire logic [MXDEC_MASTERS-1:0] m_ack,
    input wire logic [MXDEC_MASTERS-1:0] m_err,
    input mxdec_slave_t                  m_slave [MXDEC_MASTERS],
    input wire logic [MXDEC_N_CS-1:0]    m_cs [MXDEC_MASTERS],
    input wire logic [2:0]               m_blk [MXDEC_MASTERS]
);
    // Idle masters start quiet
    initial begin
        m_req = '0;
        foreach (m_addr[k]) m_addr[k] = 32'h0;
    end

    // One-cycle request; answer read just after it drops
    task automatic access(input int id, input logic [31:0] a, output logic ack,
                          output logic err, output mxdec_slave_t sl,
                          output logic [8:0] cs, output logic [2:0] blk);
        @(posedge ref_clk);
        #2;
        m_req[id] = 1'b1;
        m_addr[id] = a;
        @(posedge ref_clk);
        #2;
        m_req[id] = 1'b0;
        // Released address shows its inverse so a stale value is never reused
        m_addr[id] = ~a;
        ack = m_ack[id];
        err = m_err[id];
        sl = m_slave[id];
        cs = m_cs[id];
        blk = m_blk[id];
    endtask
endmodule

// ===== sim/mxdec_top_bench.sv
// Self-checking bench for the bus matrix decoder and boot map
`timescale 1ns/1ps
module mxdec_top_bench;
    import mxdec_pkg::*;
    // Stimulus and status
    logic                     ref_clk, rstn, boot_source_pin, cfg_wr, cfg_alias;
    logic [SZ_W-1:0]          cfg_a_size, cfg_b_size, a_size, b_size;
    logic                     boot_done, boot_rom, alias_on;
    logic [2:0]               c_size;
    // Master traffic
    logic [MXDEC_MASTERS-1:0] m_req, m_ack, m_err;
    logic [31:0]              m_addr [MXDEC_MASTERS];
    mxdec_slave_t             m_slave [MXDEC_MASTERS];
    logic [MXDEC_N_CS-1:0]    m_cs [MXDEC_MASTERS];
    logic [2:0]               m_blk [MXDEC_MASTERS];
    int                       fails, n_tests;

    mxdec_top u_mxdec_top (.ref_clk, .rstn, .boot_source_pin, .cfg_wr, .cfg_alias, .cfg_a_size,
        .cfg_b_size, .boot_done, .boot_rom, .alias_on, .a_size, .b_size, .c_size, .m_req,
        .m_addr, .m_ack, .m_err, .m_slave, .m_cs, .m_blk, .m_blk_off());
    mxdec_master_model u_mxdec_master_model (.ref_clk, .m_req, .m_addr, .m_ack, .m_err,
        .m_slave, .m_cs, .m_blk);

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access; block matters only for the 80 KB SRAM
    task automatic probe(input int id, input logic [31:0] a, input logic e_err,
                         input mxdec_slave_t e_sl, input logic [8:0] e_cs, input logic [2:0] e_blk);
        logic ack, err;
        mxdec_slave_t sl;
        logic [8:0] cs;
        logic [2:0] blk;
        u_mxdec_master_model.access(id, a, ack, err, sl, cs, blk);
        check("ack", 10'(ack), 10'h1);
        check("err", 10'(err), 10'(e_err));
        check("slave", sl, e_sl);
        check("cs", 10'(cs), 10'(e_cs));
        if (e_sl == SL_SRAM80) check("blk", 10'(blk), 10'(e_blk));
    endtask

    // Alias and sizes written together
    task automatic cfg_write(input logic al, input logic [1:0] a, input logic [1:0] b);
        @(posedge ref_clk);
        #2;
        {cfg_wr, cfg_alias, cfg_a_size, cfg_b_size} = {1'b1, al, a, b};
        @(posedge ref_clk);
        #2;
        cfg_wr = 1'b0;
    endtask

    task automatic reset_and_boot(input logic pin);
        boot_source_pin = pin;
        rstn = 1'b0;
        repeat (8) @(posedge ref_clk);
        #2;
        rstn = 1'b1;
        check("alias", 10'(alias_on), 10'h0);
        check("c_size", 10'(c_size), 10'h5);
        for (int k = 0; k < 40 && boot_done !== 1'b1; k++) begin
            @(posedge ref_clk);
            #2;
        end
        check("boot_done", 10'(boot_done), 10'h1);
        check("boot_rom", 10'(boot_rom), 10'(pin));
    endtask

    // Pin moves after capture; address zero must stay on ROM
    task automatic t_boot_rom;
        boot_source_pin = 1'b0;
        repeat (8) @(posedge ref_clk);
        #2;
        check("boot_rom", 10'(boot_rom), 10'h1);
        probe(0, 32'h0, 1'b0, SL_ROM, 9'h0, 3'h0);
        boot_source_pin = 1'b1;
    endtask

    task automatic t_banks;
        mxdec_slave_t sl;
        logic [8:0] cs;
        for (int b = 1; b < 16; b++) begin
            sl = (b <= 6) ? SL_EBI0 : (b <= 9) ? SL_EBI1 : (b == 15) ? SL_BRIDGE : SL_NONE;
            cs = (b <= 9) ? 9'h001 << (b - 1) : 9'h000;
            probe(7, {4'(b), 28'h0123450}, sl == SL_NONE, sl, cs, 3'h0);
        end
        probe(7, 32'h0060_0000, 1'b1, SL_NONE, 9'h0, 3'h0);
    endtask

    task automatic t_rights;
        logic cpu, br;
        for (int m = 0; m < MXDEC_MASTERS; m++) begin
            cpu = (m >= 7);
            br = cpu || (m == 3) || (m == 6);
            probe(m, 32'h0040_0000, 1'b0, SL_ROM, 9'h0, 3'h0);
            probe(m, 32'h0050_0000, 1'b0, SL_SRAM16, 9'h0, 3'h0);
            probe(m, 32'h7000_0000, 1'b0, SL_EBI1, 9'h040, 3'h0);
            probe(m, 32'h0070_0000, !cpu, cpu ? SL_LCD_UI : SL_NONE, 9'h0, 3'h0);
            probe(m, 32'h0080_0000, !cpu, cpu ? SL_DMA_UI : SL_NONE, 9'h0, 3'h0);
            probe(m, 32'h0090_0000, !cpu, cpu ? SL_USBH_UI : SL_NONE, 9'h0, 3'h0);
            probe(m, 32'hf000_0000, !br, br ? SL_BRIDGE : SL_NONE, 9'h0, 3'h0);
        end
    endtask

    // A and B one block each, then A clamped to 32 KB
    task automatic t_partition;
        cfg_write(1'b0, 2'h1, 2'h1);
        check("c_size", 10'(c_size), 10'h3);
        probe(2, 32'h0010_0000, 1'b0, SL_SRAM80, 9'h0, 3'h1);
        probe(2, 32'h0010_4000, 1'b1, SL_NONE, 9'h0, 3'h0);
        probe(2, 32'h0020_0000, 1'b0, SL_SRAM80, 9'h0, 3'h3);
        probe(2, 32'h0030_4000, 1'b0, SL_SRAM80, 9'h0, 3'h2);
        probe(2, 32'h0030_8000, 1'b0, SL_SRAM80, 9'h0, 3'h0);
        probe(2, 32'h0030_c000, 1'b1, SL_NONE, 9'h0, 3'h0);
        cfg_write(1'b0, 2'h3, 2'h2);
        check("a_size", 10'(a_size), 10'h2);
        check("c_size", 10'(c_size), 10'h1);
        probe(7, 32'h0010_4000, 1'b0, SL_SRAM80, 9'h0, 3'h0);
        probe(7, 32'h0030_4000, 1'b1, SL_NONE, 9'h0, 3'h0);
    endtask

    // Alias set only after boot
    task automatic t_alias;
        cfg_write(1'b1, 2'h0, 2'h0);
        probe(7, 32'h0, 1'b0, SL_SRAM80, 9'h0, 3'h4);
        probe(8, 32'h0, 1'b0, SL_SRAM80, 9'h0, 3'h4);
        probe(0, 32'h0, 1'b0, SL_ROM, 9'h0, 3'h0);
        probe(3, 32'h0030_0000, 1'b0, SL_SRAM80, 9'h0, 3'h4);
        cfg_write(1'b0, 2'h0, 2'h0);
        probe(7, 32'h0, 1'b0, SL_ROM, 9'h0, 3'h0);
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        {fails, n_tests} = '0;
        {cfg_wr, cfg_alias, cfg_a_size, cfg_b_size} = '0;
        reset_and_boot(1'b1);
        t_boot_rom();
        t_banks();
        t_rights();
        t_partition();
        t_alias();
        reset_and_boot(1'b0);
        probe(7, 32'h0, 1'b0, SL_EBI0, 9'h001, 3'h0);
        tally_and_finish();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule
